// >>> core/dei_pkg.sv
// constants, register map and state codes for the drive enable interlock
package dei_pkg;

	//////////////////////////////////////////////////////////////////////
	// timing: sample periods in microseconds, clock in hertz
	localparam int DEI_CLOCK_HZ = 100_000_000;
	localparam int DEI_HZ_PER_MHZ = 1_000_000;
	localparam int DEI_ENABLE_SAMPLE_US = 1000;
	localparam int DEI_GENERAL_SAMPLE_US = 2000;
	localparam int DEI_SWITCH_SAMPLE_US = 100_000;
	localparam int DEI_CYCLES_PER_US = DEI_CLOCK_HZ / DEI_HZ_PER_MHZ;
	localparam int DEI_ENABLE_SAMPLE_CYCLES =
		DEI_CYCLES_PER_US * DEI_ENABLE_SAMPLE_US;
	localparam int DEI_GENERAL_SAMPLE_CYCLES =
		DEI_CYCLES_PER_US * DEI_GENERAL_SAMPLE_US;
	localparam int DEI_SWITCH_SAMPLE_CYCLES =
		DEI_CYCLES_PER_US * DEI_SWITCH_SAMPLE_US;

	//////////////////////////////////////////////////////////////////////
	// general inputs
	localparam int DEI_GENERAL_INPUTS = 8;
	localparam int DEI_SELECT_W = 3;

	//////////////////////////////////////////////////////////////////////
	// register map, byte addresses on a word-aligned bus
	localparam int DEI_ADDR_W = 4;
	localparam logic [3:0] DEI_REG_CONTROL = 4'h0;
	localparam logic [3:0] DEI_REG_STATUS = 4'h4;
	localparam logic [3:0] DEI_REG_EVENT = 4'h8;
	localparam logic [3:0] DEI_REG_MASK = 4'hC;

	// control fields
	localparam int DEI_CTL_CMD_WRITE = 0;
	localparam int DEI_CTL_CMD_RESET = 1;
	localparam int DEI_CTL_COMBINED = 2;
	localparam int DEI_CTL_POLARITY = 3;
	localparam int DEI_CTL_HW_CMD = 4;
	localparam int DEI_CTL_CMD_CLEAR = 5;
	localparam int DEI_CTL_SEL_LSB = 8;

	// status fields
	localparam int DEI_ST_ENABLE_IN = 0;
	localparam int DEI_ST_SWITCH = 1;
	localparam int DEI_ST_ENABLED = 2;
	localparam int DEI_ST_COMMAND = 3;
	localparam int DEI_ST_ARMED = 4;
	localparam int DEI_ST_INPUTS_LSB = 8;

	// event fields, shared by event and mask registers
	localparam int DEI_EVENTS = 3;
	localparam int DEI_EV_ENABLED = 0;
	localparam int DEI_EV_DROPPED = 1;
	localparam int DEI_EV_COMMAND = 2;

	// reset values
	localparam logic DEI_POLARITY_RESET = 1'b1;
	localparam logic [2:0] DEI_MASK_RESET = 3'h0;

	//////////////////////////////////////////////////////////////////////
	// interlock states, one-hot
	typedef enum logic [2:0] {
		DEI_WAIT_EDGE = 3'h1,
		DEI_ARMED = 3'h2,
		DEI_ENABLED = 3'h4
	} dei_state_t;

endpackage : dei_pkg

// >>> core/dei_interlock.sv
// drive enable interlock with avalon-mm register slave
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module dei_interlock
	import dei_pkg::*;
#(
	parameter int ENABLE_SAMPLE_CYCLES = DEI_ENABLE_SAMPLE_CYCLES,
	parameter int GENERAL_SAMPLE_CYCLES = DEI_GENERAL_SAMPLE_CYCLES,
	parameter int SWITCH_SAMPLE_CYCLES = DEI_SWITCH_SAMPLE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [DEI_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_enable_input,
	input wire logic i_local_switch,
	input wire logic [DEI_GENERAL_INPUTS-1:0] i_general_input,
	output logic o_drive_enabled,
	output logic o_irq
);

	//////////////////////////////////////////////////////////////////////
	// counter widths follow the sample periods
	localparam int C1_W = $clog2(ENABLE_SAMPLE_CYCLES + 1);
	localparam int C2_W = $clog2(GENERAL_SAMPLE_CYCLES + 1);
	localparam int C3_W = $clog2(SWITCH_SAMPLE_CYCLES + 1);
	localparam logic [C1_W-1:0] C1_LAST = C1_W'(ENABLE_SAMPLE_CYCLES - 1);
	localparam logic [C2_W-1:0] C2_LAST = C2_W'(GENERAL_SAMPLE_CYCLES - 1);
	localparam logic [C3_W-1:0] C3_LAST = C3_W'(SWITCH_SAMPLE_CYCLES - 1);
	localparam int GI = DEI_GENERAL_INPUTS;

	typedef struct packed {
		logic [C1_W-1:0] cnt_enable;
		logic [C2_W-1:0] cnt_general;
		logic [C3_W-1:0] cnt_switch;
		logic en_meta;
		logic en_sync;
		logic sw_meta;
		logic sw_sync;
		logic [GI-1:0] gi_meta;
		logic [GI-1:0] gi_sync;
		logic en_smp;
		logic sw_smp;
		logic [GI-1:0] gi_smp;
		dei_state_t state;
		logic cmd;
		logic combined;
		logic polarity;
		logic hw_cmd;
		logic [DEI_SELECT_W-1:0] sel;
		logic [DEI_EVENTS-1:0] events;
		logic [DEI_EVENTS-1:0] mask;
		logic ack;
		logic [31:0] rdata;
		logic enabled;
	} dei_regs_t;

	// everything but polarity starts cleared, waiting for a fresh edge
	localparam dei_regs_t REGS_RESET = '{
		state: DEI_WAIT_EDGE,
		polarity: DEI_POLARITY_RESET,
		mask: DEI_MASK_RESET,
		default: '0
	};

	dei_regs_t r_q;
	dei_regs_t r_d;

	//////////////////////////////////////////////////////////////////////
	// combinational helpers
	logic tick_enable;
	logic tick_general;
	logic tick_switch;
	logic en_new;
	logic sw_new;
	logic [GI-1:0] gi_new;
	logic en_rise;
	logic en_fall;
	logic sw_rise;
	logic sel_rise;
	logic combined_cmd;
	logic bus_req;
	logic bus_done;
	logic wr_ctl;
	logic sw_cmd;
	logic cmd_event;
	logic [DEI_EVENTS-1:0] ev_set;
	logic [31:0] rd_value;
	logic [31:0] status_word;
	logic [31:0] control_word;

	// sample ticks: one-cycle enables from free-running dividers
	always_comb begin
		tick_enable = (r_q.cnt_enable == C1_LAST);
		tick_general = (r_q.cnt_general == C2_LAST);
		tick_switch = (r_q.cnt_switch == C3_LAST);
	end

	// next sample values; a sample only moves on its own tick
	always_comb begin
		en_new = tick_enable ? r_q.en_sync : r_q.en_smp;
		sw_new = tick_switch ? r_q.sw_sync : r_q.sw_smp;
		// polarity applies to the general inputs only
		gi_new = tick_general ?
			(r_q.polarity ? r_q.gi_sync : ~r_q.gi_sync) :
			r_q.gi_smp;
	end

	// edges are judged between two consecutive samples only
	always_comb begin
		en_rise = tick_enable & ~r_q.en_smp & r_q.en_sync;
		en_fall = tick_enable & r_q.en_smp & ~r_q.en_sync;
		sw_rise = tick_switch & ~r_q.sw_smp & r_q.sw_sync;
		// a short pulse between two 2 ms samples is never seen
		sel_rise = r_q.hw_cmd & ~r_q.gi_smp[r_q.sel] &
			gi_new[r_q.sel];
		// one input already on while the other comes on
		combined_cmd = r_q.combined &
			((en_rise & r_q.sw_smp) | (sw_rise & en_new));
	end

	//////////////////////////////////////////////////////////////////////
	// bus decode: one wait state, so read data comes from a flop
	always_comb begin
		bus_req = i_avs_read | i_avs_write;
		bus_done = bus_req & r_q.ack;
		wr_ctl = bus_done & i_avs_write &
			(i_avs_address == DEI_REG_CONTROL);
		sw_cmd = wr_ctl & (i_avs_writedata[DEI_CTL_CMD_WRITE] |
			i_avs_writedata[DEI_CTL_CMD_RESET]);
		cmd_event = sw_cmd | sel_rise | combined_cmd;
	end

	// read words; status bits are read-only views of the samples and the interlock state
	always_comb begin
		control_word = '0;
		control_word[DEI_CTL_COMBINED] = r_q.combined;
		control_word[DEI_CTL_POLARITY] = r_q.polarity;
		control_word[DEI_CTL_HW_CMD] = r_q.hw_cmd;
		control_word[DEI_CTL_SEL_LSB +: DEI_SELECT_W] = r_q.sel;
		status_word = '0;
		status_word[DEI_ST_ENABLE_IN] = r_q.en_smp;
		status_word[DEI_ST_SWITCH] = r_q.sw_smp;
		status_word[DEI_ST_ENABLED] = r_q.enabled;
		status_word[DEI_ST_COMMAND] = r_q.cmd;
		status_word[DEI_ST_ARMED] = (r_q.state != DEI_WAIT_EDGE);
		status_word[DEI_ST_INPUTS_LSB +: GI] = r_q.gi_smp;
		case (i_avs_address)
			DEI_REG_CONTROL: rd_value = control_word;
			DEI_REG_STATUS: rd_value = status_word;
			DEI_REG_EVENT: rd_value = {{(32 - DEI_EVENTS){1'b0}}, r_q.events};
			DEI_REG_MASK: rd_value = {{(32 - DEI_EVENTS){1'b0}}, r_q.mask};
			default: rd_value = '0; // unmapped reads as zero
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// next state of everything
	always_comb begin
		r_d = r_q;
		ev_set = '0;

		// dividers
		r_d.cnt_enable = tick_enable ? '0 : r_q.cnt_enable + 1'b1;
		r_d.cnt_general = tick_general ? '0 : r_q.cnt_general + 1'b1;
		r_d.cnt_switch = tick_switch ? '0 : r_q.cnt_switch + 1'b1;

		// two-flop synchronisers on every pin
		r_d.en_meta = i_enable_input;
		r_d.en_sync = r_q.en_meta;
		r_d.sw_meta = i_local_switch;
		r_d.sw_sync = r_q.sw_meta;
		r_d.gi_meta = i_general_input;
		r_d.gi_sync = r_q.gi_meta;

		r_d.en_smp = en_new;
		r_d.sw_smp = sw_new;
		r_d.gi_smp = gi_new;

		// bus handshake: first cycle loads data, second completes
		r_d.ack = bus_req & ~r_q.ack;
		if (bus_req & ~r_q.ack) begin
			r_d.rdata = rd_value;
		end

		// control register writes
		if (wr_ctl) begin
			r_d.combined = i_avs_writedata[DEI_CTL_COMBINED];
			r_d.polarity = i_avs_writedata[DEI_CTL_POLARITY];
			r_d.hw_cmd = i_avs_writedata[DEI_CTL_HW_CMD];
			r_d.sel = i_avs_writedata[DEI_CTL_SEL_LSB +: DEI_SELECT_W];
			if (i_avs_writedata[DEI_CTL_CMD_CLEAR]) begin
				r_d.cmd = 1'b0;
			end
		end
		if (bus_done & i_avs_write & (i_avs_address == DEI_REG_MASK)) begin
			r_d.mask = i_avs_writedata[DEI_EVENTS-1:0];
		end

		// command latch; an arriving command beats a control-register clear, but a fall in DEI_ENABLED still clears it
		if (cmd_event) begin
			r_d.cmd = 1'b1;
			ev_set[DEI_EV_COMMAND] = 1'b1;
		end

		// interlock sequence
		case (r_q.state)
			DEI_WAIT_EDGE: begin
				// only a clean inactive-then-active pair arms
				if (en_rise) begin
					r_d.state = DEI_ARMED;
				end
			end
			DEI_ARMED: begin
				if (en_fall) begin
					r_d.state = DEI_WAIT_EDGE;
				end else if (r_q.sw_smp & r_q.cmd) begin
					r_d.state = DEI_ENABLED;
					ev_set[DEI_EV_ENABLED] = 1'b1;
				end
			end
			DEI_ENABLED: begin
				// bounce counts too: any sampled fall drops the drive
				if (en_fall) begin
					r_d.state = DEI_WAIT_EDGE;
					r_d.cmd = 1'b0;
					ev_set[DEI_EV_DROPPED] = 1'b1;
				end else if (~r_q.sw_smp | ~r_q.cmd) begin
					r_d.state = DEI_ARMED;
					ev_set[DEI_EV_DROPPED] = 1'b1;
				end
			end
			default: begin
				r_d.state = DEI_WAIT_EDGE;
			end
		endcase

		// output follows the state without waiting a further cycle
		r_d.enabled = (r_d.state == DEI_ENABLED) & ~en_fall;

		// sticky events cleared by a read; a new event wins
		if (bus_done & i_avs_read & (i_avs_address == DEI_REG_EVENT)) begin
			r_d.events = '0;
		end
		r_d.events = r_d.events | ev_set;
	end

	//////////////////////////////////////////////////////////////////////
	// the single state register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			r_q <= REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		o_avs_waitrequest = bus_req & ~r_q.ack;
		o_avs_readdata = r_q.rdata;
		o_drive_enabled = r_q.enabled;
		o_irq = |(r_q.events & r_q.mask);
	end

endmodule : dei_interlock

// >>> sim/dei_interlock_chk.sv
// port-level assertion checker for the drive enable interlock
`timescale 1ns/100ps
module dei_interlock_chk
	import dei_pkg::*;
#(
	parameter int ENABLE_SAMPLE_CYCLES = DEI_ENABLE_SAMPLE_CYCLES,
	parameter int GENERAL_SAMPLE_CYCLES = DEI_GENERAL_SAMPLE_CYCLES,
	parameter int SWITCH_SAMPLE_CYCLES = DEI_SWITCH_SAMPLE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [DEI_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_enable_input,
	input wire logic i_local_switch,
	input wire logic [DEI_GENERAL_INPUTS-1:0] i_general_input,
	input wire logic o_drive_enabled,
	input wire logic o_irq
);
	//////////////////////////////////////////
	// replica of the enable and switch samplers, restarted by reset like the block
	logic [1:0] en_s_q, sw_s_q;
	logic en_q, sw_q, edge_q;
	int ec_q, sc_q;
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			{en_s_q, sw_s_q, en_q, sw_q, edge_q} <= '0;
			ec_q <= 0;
			sc_q <= 0;
		end else begin
			en_s_q <= {en_s_q[0], i_enable_input};
			sw_s_q <= {sw_s_q[0], i_local_switch};
			ec_q <= (ec_q == ENABLE_SAMPLE_CYCLES - 1) ? 0 : ec_q + 1;
			sc_q <= (sc_q == SWITCH_SAMPLE_CYCLES - 1) ? 0 : sc_q + 1;
			// edge memory: low-then-high pair seen, lost on any low sample
			if (ec_q == ENABLE_SAMPLE_CYCLES - 1) begin
				en_q <= en_s_q[1];
				edge_q <= en_s_q[1] & (edge_q | ~en_q);
			end
			if (sc_q == SWITCH_SAMPLE_CYCLES - 1)
				sw_q <= sw_s_q[1];
		end
	end
	//////////////////////////////////////////
	// bus and interlock properties
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	sequence s_req;
		$rose(i_avs_read | i_avs_write);
	endsequence
	sequence s_rd(logic [3:0] a);
		i_avs_read && !o_avs_waitrequest && i_avs_address == a;
	endsequence
	a_bus_one_wait: assert property (s_req |-> o_avs_waitrequest
		##1 !o_avs_waitrequest) else $error("wait state count wrong");
	a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
		&& i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctl_pulse_zero: assert property (
		s_rd(DEI_REG_CONTROL) |-> o_avs_readdata[1:0] == 2'h0)
		else $error("command pulse bits read back");
	a_status_readback: assert property (
		s_rd(DEI_REG_STATUS) |-> o_avs_readdata[2:0] ==
		{$past(o_drive_enabled), $past(sw_q), $past(en_q)})
		else $error("status readback wrong");
	a_mask_quiets_irq: assert property (i_avs_write && !o_avs_waitrequest
		&& i_avs_address == DEI_REG_MASK && i_avs_writedata[2:0] == 3'h0
		|=> !o_irq) else $error("irq high with mask clear");
	a_enable_needs_pin: assert property (
		o_drive_enabled |-> en_q) else $error("enabled without input");
	a_fall_drops_now: assert property (
		$fell(en_q) |-> !o_drive_enabled [*3])
		else $error("fall did not disable");
	a_rise_needs_edge: assert property (
		$rose(o_drive_enabled) |-> edge_q)
		else $error("enabled without edge");
	a_switch_off_drops: assert property (
		$fell(sw_q) |-> ##[0:1] !o_drive_enabled)
		else $error("switch off kept drive");
	a_reset_clears: assert property (
		$rose(i_resetn) |-> !o_drive_enabled [*2])
		else $error("drive on after reset");
endmodule : dei_interlock_chk

bind dei_interlock dei_interlock_chk #(
	.ENABLE_SAMPLE_CYCLES(ENABLE_SAMPLE_CYCLES),
	.GENERAL_SAMPLE_CYCLES(GENERAL_SAMPLE_CYCLES),
	.SWITCH_SAMPLE_CYCLES(SWITCH_SAMPLE_CYCLES)
) u_dei_interlock_chk (.i_clock(i_clock), .i_resetn(i_resetn),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_enable_input(i_enable_input), .i_local_switch(i_local_switch),
	.i_general_input(i_general_input), .o_drive_enabled(o_drive_enabled),
	.o_irq(o_irq));

// >>> sim/dei_field_model.sv
// field wiring model: enable input, front switch and general inputs
`timescale 1ns/100ps
module dei_field_model (
	input wire logic i_en,
	input wire logic i_sw,
	input wire logic [7:0] i_din,
	input wire logic i_low_wired,
	output logic o_enable_input,
	output logic o_local_switch,
	output logic [7:0] o_general_input
);
	// the common reference flips general inputs only, never the enable pin
	assign o_enable_input = i_en;
	assign o_local_switch = i_sw;
	assign o_general_input = i_din ^ {8{i_low_wired}};
endmodule : dei_field_model

// >>> sim/dei_interlock_tb_top.sv
// self-checking bench for the drive enable interlock
`timescale 1ns/100ps
module dei_interlock_tb_top
	import dei_pkg::*;
;
	logic i_clock = 1'h0;
	logic i_resetn = 1'h0;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic en = 1'h0;
	logic sw = 1'h0;
	logic lw = 1'h0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [7:0] din = 8'h0;
	logic [31:0] q, rdat;
	logic wreq, drv, irq, p_en, p_sw;
	logic [7:0] p_g;
	int errors = 0;
	int total_checks = 0;

	// small sample periods keep the run short
	dei_interlock #(.ENABLE_SAMPLE_CYCLES(4), .GENERAL_SAMPLE_CYCLES(8),
		.SWITCH_SAMPLE_CYCLES(16)) u_dei_interlock (.i_clock(i_clock),
		.i_resetn(i_resetn), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wreq), .i_enable_input(p_en),
		.i_local_switch(p_sw), .i_general_input(p_g),
		.o_drive_enabled(drv), .o_irq(irq));
	dei_field_model u_dei_field_model (.i_en(en), .i_sw(sw), .i_din(din),
		.i_low_wired(lw), .o_enable_input(p_en), .o_local_switch(p_sw),
		.o_general_input(p_g));

	//////////////////////////////////////////
	// shared helpers; every task that waits starts and ends just after a rising edge
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// single-bit outputs are looked at mid-cycle, away from the edge
	task automatic cs(input string n, input logic e, ref logic g);
		@(negedge i_clock);
		chk(n, {31'h0, e}, {31'h0, g});
		@(posedge i_clock);
	endtask : cs
	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
	endtask : wt
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(negedge i_clock);
			q = rdat;
			n++;
		end while (wreq !== 1'h0 && n < 20);
		@(posedge i_clock);
		rd <= 1'h0;
		wr <= 1'h0;
		if (n >= 20) errors++;
		@(posedge i_clock);
	endtask : bus

	//////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		bus(1'h0, DEI_REG_CONTROL, 32'h0);
		chk("control", 32'h8, q);
		bus(1'h0, DEI_REG_STATUS, 32'h0);
		chk("status", 32'h0, q);
	endtask : t_reset
	task automatic t_soft;
		sw <= 1'h1;
		en <= 1'h1;
		wt(40);
		cs("drive", 1'h0, drv);
		bus(1'h1, DEI_REG_CONTROL, 32'h9);
		cs("drive", 1'h1, drv);
		bus(1'h1, DEI_REG_STATUS, 32'h0);
		bus(1'h0, DEI_REG_STATUS, 32'h0);
		chk("status", 32'h7, q & 32'h7);
	endtask : t_soft
	// a one-sample dropout acts as a low-then-high pair
	task automatic t_fall;
		en <= 1'h0;
		wt(4);
		en <= 1'h1;
		wt(12);
		cs("drive", 1'h0, drv);
		bus(1'h1, DEI_REG_CONTROL, 32'hA);
		cs("drive", 1'h1, drv);
	endtask : t_fall
	task automatic t_switch;
		sw <= 1'h0;
		wt(40);
		cs("drive", 1'h0, drv);
		bus(1'h0, DEI_REG_STATUS, 32'h0);
		chk("switch", 32'h0, q & 32'h2);
		bus(1'h1, DEI_REG_CONTROL, 32'h28);
		sw <= 1'h1;
		wt(40);
		cs("drive", 1'h0, drv);
	endtask : t_switch
	// wiring goes active low before the polarity bit follows it
	task automatic t_hw;
		lw <= 1'h1;
		wt(24);
		bus(1'h1, DEI_REG_CONTROL, 32'h510);
		din <= 8'h04;
		wt(24);
		bus(1'h0, DEI_REG_STATUS, 32'h0);
		chk("inputs", 32'h04, {24'h0, q[15:8]});
		cs("drive", 1'h0, drv);
		din <= 8'h24;
		wt(24);
		cs("drive", 1'h1, drv);
		din <= 8'h00;
	endtask : t_hw
	task automatic t_comb;
		en <= 1'h0;
		wt(12);
		bus(1'h1, DEI_REG_CONTROL, 32'h4);
		en <= 1'h1;
		wt(12);
		cs("drive", 1'h1, drv);
		sw <= 1'h0;
		wt(40);
		cs("drive", 1'h0, drv);
		// drop the latched command so only the switch rise can give it back
		bus(1'h1, DEI_REG_CONTROL, 32'h24);
		sw <= 1'h1;
		wt(40);
		cs("drive", 1'h1, drv);
	endtask : t_comb
	task automatic t_irq;
		cs("irq", 1'h0, irq);
		bus(1'h1, DEI_REG_MASK, 32'h7);
		cs("irq", 1'h1, irq);
		bus(1'h0, DEI_REG_EVENT, 32'h0);
		chk("event", 32'h7, q);
		bus(1'h0, 4'h6, 32'h0);
		chk("unmapped", 32'h0, q);
		cs("irq", 1'h0, irq);
	endtask : t_irq
	task automatic t_rst2;
		i_resetn <= 1'h0;
		wt(2);
		cs("drive", 1'h0, drv);
		i_resetn <= 1'h1;
		bus(1'h0, DEI_REG_CONTROL, 32'h0);
		chk("control", 32'h8, q);
	endtask : t_rst2

	//////////////////////////////////////////
	// clock, main sequence, watchdog and verdict
	task automatic end_of_test;
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial forever #5 i_clock = ~i_clock;
	initial begin
		repeat (2) @(posedge i_clock);
		i_resetn <= 1'h1;
		@(posedge i_clock);
		t_reset;
		t_soft;
		t_fall;
		t_switch;
		t_hw;
		t_comb;
		t_irq;
		t_rst2;
		end_of_test;
	end
	// the scenarios need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_clock);
		errors++;
		end_of_test;
	end
endmodule : dei_interlock_tb_top
